/* File: hw/tsfb_pkg.sv */
package tsfb_pkg;
  localparam int NUM_CH = 5;
  localparam int NUM_EXT = 4;
  localparam int TEMP_W = 11;
  localparam int FRAC_W = 3;

  localparam logic [7:0] ADDR_SUMMARY = 8'h2A;
  localparam logic [7:0] ADDR_FAULT = 8'h2B;
  localparam logic [7:0] ADDR_UPPER = 8'h2C;
  localparam logic [7:0] ADDR_LOWER = 8'h2D;
  localparam logic [7:0] ADDR_OVERTEMP = 8'h2E;
  localparam logic [7:0] ADDR_HOT_INT = 8'h2F;
  localparam logic [7:0] ADDR_HOT_FRAC = 8'h30;

  localparam int SUM_CHG_BIT = 6;
  localparam int SUM_BUSY_BIT = 5;
  localparam int SUM_HIGH_BIT = 4;
  localparam int SUM_LOW_BIT = 3;
  localparam int SUM_FAULT_BIT = 2;
  localparam int SUM_EXT_OT_BIT = 1;
  localparam int SUM_INT_OT_BIT = 0;
  localparam int OT_HW_BIT = 7;
  localparam int FRAC_LSB = 5;

  localparam logic [7:0] SUMMARY_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] HOT_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  localparam logic [7:0] HW_SDN_HYST = 8'h0A;
endpackage

/* File: hw/tsfb_hottest.sv */
`timescale 1ns/1ps
`default_nettype none
module tsfb_hottest (
  input  wire logic [tsfb_pkg::NUM_CH-1:0][tsfb_pkg::TEMP_W-1:0] temps,
  output logic      [2:0]                                        hot_idx,
  output logic      [tsfb_pkg::TEMP_W-1:0]                       hot_val
);
  import tsfb_pkg::*;

  // Ties keep the lower channel, so equal readings never flip the index
  always_comb begin
    hot_idx = 3'h0;
    hot_val = temps[0];
    for (int i = 1; i < NUM_CH; i++) begin
      if (temps[i] > hot_val) begin
        hot_idx = 3'(i);
        hot_val = temps[i];
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/tsfb_rc_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module tsfb_rc_flags #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] set_vec,
  input  wire logic         clr,
  output logic      [W-1:0] flags_r
);
  typedef struct packed {
    logic [W-1:0] flags;
  } tsfb_rc_state_t;

  tsfb_rc_state_t s_r;
  tsfb_rc_state_t s_nxt;

  // A set in the clearing cycle survives the read
  always_comb begin
    s_nxt = s_r;
    if (clr) begin
      s_nxt.flags = '0;
    end
    s_nxt.flags = s_nxt.flags | set_vec;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flags_r = s_r.flags;
endmodule
`default_nettype wire

/* File: hw/tsfb_flag_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module tsfb_flag_bank (
  input  wire logic                                              clk,
  input  wire logic                                              reset,
  input  wire logic                                              meas_done,
  input  wire logic                                              conv_busy,
  input  wire logic [tsfb_pkg::NUM_CH-1:0][tsfb_pkg::TEMP_W-1:0] ch_temp,
  input  wire logic [tsfb_pkg::NUM_CH-1:0][7:0]                  upper_limit,
  input  wire logic [tsfb_pkg::NUM_CH-1:0][7:0]                  lower_limit,
  input  wire logic [tsfb_pkg::NUM_CH-1:0][7:0]                  overtemp_limit,
  input  wire logic [7:0]                                        overtemp_hyst,
  input  wire logic [7:0]                                        hw_shutdown_limit,
  input  wire logic [tsfb_pkg::NUM_EXT-1:0]                      diode_fault,
  input  wire logic [tsfb_pkg::NUM_CH-1:0]                       alert_mask,
  input  wire logic                                              rd_stb,
  input  wire logic [7:0]                                        rd_addr,
  output logic      [7:0]                                        rd_data_r,
  output logic                                                   alert_pin_oe_r,
  output logic                                                   overtemp_pin_oe_r,
  output logic                                                   system_shutdown_pin_oe_r
);
  import tsfb_pkg::*;

  typedef struct packed {
    logic [NUM_CH-1:0] ot;
    logic              hw_sdn;
    logic              sum_high;
    logic              sum_low;
    logic              sum_fault;
    logic              hot_chg;
    logic [2:0]        hot_idx;
    logic [TEMP_W-1:0] hot_val;
    logic              busy;
    logic [7:0]        rd_data;
    logic              alert;
    logic              ot_pin;
    logic              sdn_pin;
  } tsfb_bank_state_t;

  tsfb_bank_state_t s_r;
  tsfb_bank_state_t s_nxt;

  logic [NUM_CH-1:0]  above_upper;
  logic [NUM_CH-1:0]  below_lower;
  logic [NUM_CH-1:0]  ot_set;
  logic [NUM_CH-1:0]  ot_release;
  logic [NUM_EXT-1:0] fault_r;
  logic [NUM_CH-1:0]  upper_r;
  logic [NUM_CH-1:0]  lower_r;
  logic [2:0]         new_idx;
  logic [TEMP_W-1:0]  new_val;
  logic               rd_fault;
  logic               rd_upper;
  logic               rd_lower;
  logic               hw_set;
  logic               hw_release;
  logic [7:0]         hw_floor;

  // Saturating floor keeps a small limit from wrapping to a huge threshold
  function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [7:0] b);
    sat_sub = (a > b) ? (a - b) : 8'h00;
  endfunction

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_addr);
    addr_is = (a == ref_addr);
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_cmp
      // Compare at full resolution, except the overtemp release, which uses the integer part: any fraction above the integer limit counts
      assign above_upper[g] = ch_temp[g] > {upper_limit[g], {FRAC_W{1'b0}}};
      assign below_lower[g] = ch_temp[g] < {lower_limit[g], {FRAC_W{1'b0}}};
      assign ot_set[g] = ch_temp[g] > {overtemp_limit[g], {FRAC_W{1'b0}}};
      assign ot_release[g] =
        ch_temp[g][TEMP_W-1:FRAC_W] < sat_sub(overtemp_limit[g], overtemp_hyst);
    end
  endgenerate

  assign hw_floor = sat_sub(hw_shutdown_limit, HW_SDN_HYST);
  assign hw_set = ch_temp[1][TEMP_W-1:FRAC_W] > hw_shutdown_limit;
  assign hw_release = ch_temp[1][TEMP_W-1:FRAC_W] < hw_floor;

  assign rd_fault = rd_stb && addr_is(rd_addr, ADDR_FAULT);
  assign rd_upper = rd_stb && addr_is(rd_addr, ADDR_UPPER);
  assign rd_lower = rd_stb && addr_is(rd_addr, ADDR_LOWER);

  tsfb_hottest u_hottest (
    .temps   (ch_temp),
    .hot_idx (new_idx),
    .hot_val (new_val)
  );

  tsfb_rc_flags #(.W(NUM_EXT)) u_fault (
    .clk     (clk),
    .reset   (reset),
    .set_vec (meas_done ? diode_fault : '0),
    .clr     (rd_fault),
    .flags_r (fault_r)
  );

  tsfb_rc_flags #(.W(NUM_CH)) u_upper (
    .clk     (clk),
    .reset   (reset),
    .set_vec (meas_done ? above_upper : '0),
    .clr     (rd_upper),
    .flags_r (upper_r)
  );

  tsfb_rc_flags #(.W(NUM_CH)) u_lower (
    .clk     (clk),
    .reset   (reset),
    .set_vec (meas_done ? below_lower : '0),
    .clr     (rd_lower),
    .flags_r (lower_r)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.busy = conv_busy;
    // Clears first, so a measurement in the same cycle wins
    if (rd_upper) begin
      s_nxt.sum_high = 1'b0;
    end
    if (rd_lower) begin
      s_nxt.sum_low = 1'b0;
    end
    if (rd_fault) begin
      s_nxt.sum_fault = 1'b0;
    end
    if (meas_done) begin
      if (|(above_upper & ~alert_mask)) begin
        s_nxt.sum_high = 1'b1;
      end
      if (|(below_lower & ~alert_mask)) begin
        s_nxt.sum_low = 1'b1;
      end
      if (|(diode_fault & ~alert_mask[NUM_CH-1:1])) begin
        s_nxt.sum_fault = 1'b1;
      end
      // Overtemp ignores the mask; hysteresis holds the flag until release
      for (int i = 0; i < NUM_CH; i++) begin
        if (ot_set[i]) begin
          s_nxt.ot[i] = 1'b1;
        end else if (ot_release[i]) begin
          s_nxt.ot[i] = 1'b0;
        end
      end
      if (hw_set) begin
        s_nxt.hw_sdn = 1'b1;
      end else if (hw_release) begin
        s_nxt.hw_sdn = 1'b0;
      end
      s_nxt.hot_chg = (new_idx != s_r.hot_idx);
      s_nxt.hot_idx = new_idx;
      s_nxt.hot_val = new_val;
    end
    s_nxt.alert = s_r.sum_high | s_r.sum_low | s_r.sum_fault;
    s_nxt.ot_pin = |s_r.ot;
    s_nxt.sdn_pin = s_r.hw_sdn;
    // Read data is taken before the clear lands
    if (rd_stb) begin
      if (addr_is(rd_addr, ADDR_SUMMARY)) begin
        s_nxt.rd_data = SUMMARY_RST;
        s_nxt.rd_data[SUM_CHG_BIT] = s_r.hot_chg;
        s_nxt.rd_data[SUM_BUSY_BIT] = s_r.busy;
        s_nxt.rd_data[SUM_HIGH_BIT] = s_r.sum_high;
        s_nxt.rd_data[SUM_LOW_BIT] = s_r.sum_low;
        s_nxt.rd_data[SUM_FAULT_BIT] = s_r.sum_fault;
        s_nxt.rd_data[SUM_EXT_OT_BIT] = |s_r.ot[NUM_CH-1:1];
        s_nxt.rd_data[SUM_INT_OT_BIT] = s_r.ot[0];
      end else if (addr_is(rd_addr, ADDR_FAULT)) begin
        s_nxt.rd_data = {3'h0, fault_r, 1'b0};
      end else if (addr_is(rd_addr, ADDR_UPPER)) begin
        s_nxt.rd_data = {3'h0, upper_r};
      end else if (addr_is(rd_addr, ADDR_LOWER)) begin
        s_nxt.rd_data = {3'h0, lower_r};
      end else if (addr_is(rd_addr, ADDR_OVERTEMP)) begin
        s_nxt.rd_data = {s_r.hw_sdn, 2'h0, s_r.ot};
      end else if (addr_is(rd_addr, ADDR_HOT_INT)) begin
        s_nxt.rd_data = s_r.hot_val[TEMP_W-1:FRAC_W];
      end else if (addr_is(rd_addr, ADDR_HOT_FRAC)) begin
        s_nxt.rd_data = {s_r.hot_val[FRAC_W-1:0], 5'h00};
      end else begin
        s_nxt.rd_data = UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data_r = s_r.rd_data;
  assign alert_pin_oe_r = s_r.alert;
  assign overtemp_pin_oe_r = s_r.ot_pin;
  assign system_shutdown_pin_oe_r = s_r.sdn_pin;

  chk_hot_change: assert property (@(posedge clk) disable iff (reset)
    meas_done
    |=> s_r.hot_chg == ($past(new_idx) != $past(s_r.hot_idx)))
    else $error("hottest change not reported");

  chk_alert_high: assert property (@(posedge clk) disable iff (reset)
    meas_done && |(above_upper & ~alert_mask) |=> ##1 alert_pin_oe_r)
    else $error("upper violation did not drive alert");

  chk_alert_low: assert property (@(posedge clk) disable iff (reset)
    meas_done && |(below_lower & ~alert_mask) |=> ##1 alert_pin_oe_r)
    else $error("lower violation did not drive alert");

  chk_alert_fault: assert property (@(posedge clk) disable iff (reset)
    meas_done && |(diode_fault & ~alert_mask[NUM_CH-1:1]) |=> ##1 alert_pin_oe_r)
    else $error("diode fault did not drive alert");

  chk_ot_pin_follow: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> overtemp_pin_oe_r == $past(|s_r.ot))
    else $error("overtemp pin does not follow channel flags");

  chk_fault_layout: assert property (@(posedge clk) disable iff (reset)
    rd_stb && addr_is(rd_addr, ADDR_FAULT)
    |=> rd_data_r[7:5] == 3'h0 && !rd_data_r[0])
    else $error("fault register reserved bits not zero");

  chk_upper_clear: assert property (@(posedge clk) disable iff (reset)
    rd_upper && !meas_done |=> upper_r == '0 && !s_r.sum_high)
    else $error("upper read did not clear flags");

  chk_lower_clear: assert property (@(posedge clk) disable iff (reset)
    rd_lower && !meas_done |=> lower_r == '0 && !s_r.sum_low)
    else $error("lower read did not clear flags");

  chk_ot_read_keep: assert property (@(posedge clk) disable iff (reset)
    rd_stb && addr_is(rd_addr, ADDR_OVERTEMP) && !meas_done |=> $stable(s_r.ot))
    else $error("overtemp read changed flags");

  chk_frac_zero: assert property (@(posedge clk) disable iff (reset)
    rd_stb && addr_is(rd_addr, ADDR_HOT_FRAC) |=> rd_data_r[4:0] == 5'h00)
    else $error("fraction low bits not zero");

  chk_busy_bit: assert property (@(posedge clk) disable iff (reset)
    conv_busy ##1 rd_stb && addr_is(rd_addr, ADDR_SUMMARY)
    |=> rd_data_r[SUM_BUSY_BIT] && !rd_data_r[7])
    else $error("busy bit wrong");

  // Guarded so a short reset cannot compare against pre-reset state
  chk_sdn_follow: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> system_shutdown_pin_oe_r == $past(s_r.hw_sdn))
    else $error("shutdown pin does not follow shutdown flag");

  chk_alert_follow: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> alert_pin_oe_r == $past(s_r.sum_high | s_r.sum_low | s_r.sum_fault))
    else $error("alert pin does not follow summary flags");

  chk_busy_follow: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> s_r.busy == $past(conv_busy))
    else $error("busy flag does not follow conversion");

  chk_ot_set: assert property (@(posedge clk) disable iff (reset)
    meas_done && |ot_set |=> |s_r.ot)
    else $error("overtemp violation did not set a flag");

  chk_fault_clear: assert property (@(posedge clk) disable iff (reset)
    rd_fault && !meas_done |=> fault_r == '0 && !s_r.sum_fault)
    else $error("fault read did not clear flags");

  chk_upper_hold: assert property (@(posedge clk) disable iff (reset)
    !meas_done && !rd_upper |=> $stable(upper_r))
    else $error("upper flags changed outside a measurement");

  chk_lower_hold: assert property (@(posedge clk) disable iff (reset)
    !meas_done && !rd_lower |=> $stable(lower_r))
    else $error("lower flags changed outside a measurement");

  chk_fault_hold: assert property (@(posedge clk) disable iff (reset)
    !meas_done && !rd_fault |=> $stable(fault_r))
    else $error("fault flags changed outside a measurement");

  chk_hot_int_read: assert property (@(posedge clk) disable iff (reset)
    rd_stb && addr_is(rd_addr, ADDR_HOT_INT)
    |=> rd_data_r == $past(s_r.hot_val[TEMP_W-1:FRAC_W]))
    else $error("hottest integer byte wrong");

  chk_hot_frac_read: assert property (@(posedge clk) disable iff (reset)
    rd_stb && addr_is(rd_addr, ADDR_HOT_FRAC)
    |=> rd_data_r[7:5] == $past(s_r.hot_val[FRAC_W-1:0]))
    else $error("hottest fraction bits wrong");
endmodule
`default_nettype wire

/* File: sim/tsfb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tsfb_host_model (
  input  wire logic       req,
  input  wire logic [7:0] req_addr,
  input  wire logic       alert_oe,
  input  wire logic       ot_oe,
  input  wire logic       sd_oe,
  output logic            rd_stb,
  output logic      [7:0] rd_addr,
  output logic            alert_n,
  output logic            ot_n,
  output logic            sd_n
);
  assign rd_stb  = req;
  assign rd_addr = req_addr;
  // Open-drain lines with pull-ups: released means high
  assign alert_n = alert_oe ? 1'b0 : 1'b1;
  assign ot_n    = ot_oe ? 1'b0 : 1'b1;
  assign sd_n    = sd_oe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: sim/thermal_status_flag_bank_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module thermal_status_flag_bank_bench;
  import tsfb_pkg::*;
  logic clk = 1'b0, reset = 1'b1, meas_done = 1'b0, conv_busy = 1'b0, req = 1'b0;
  logic [NUM_CH-1:0][TEMP_W-1:0] ch_temp = '0, t_v;
  logic [NUM_EXT-1:0] diode_fault = '0;
  logic [NUM_CH-1:0]  alert_mask = '0;
  logic [7:0]         req_addr = 8'h00, rd_addr, rd_data_r, e;
  logic               rd_stb, stb_d = 1'b0, a_oe, o_oe, s_oe, alert_n, ot_n, sd_n;
  logic [31:0]        lfsr = 32'd84088;
  logic [2:0]         f;
  logic [7:0]         exp_q[$];
  int                 n_mismatch = 0, total_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  tsfb_flag_bank dut_u (.clk(clk), .reset(reset), .meas_done(meas_done), .conv_busy(conv_busy),
    .ch_temp(ch_temp), .upper_limit({NUM_CH{8'h50}}), .lower_limit({NUM_CH{8'h0A}}),
    .overtemp_limit({NUM_CH{8'h64}}), .overtemp_hyst(8'h05), .hw_shutdown_limit(8'h78),
    .diode_fault(diode_fault), .alert_mask(alert_mask), .rd_stb(rd_stb), .rd_addr(rd_addr),
    .rd_data_r(rd_data_r), .alert_pin_oe_r(a_oe), .overtemp_pin_oe_r(o_oe),
    .system_shutdown_pin_oe_r(s_oe));
  tsfb_host_model host_u (.req(req), .req_addr(req_addr), .alert_oe(a_oe), .ot_oe(o_oe),
    .sd_oe(s_oe), .rd_stb(rd_stb), .rd_addr(rd_addr), .alert_n(alert_n), .ot_n(ot_n),
    .sd_n(sd_n));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pins(input logic [2:0] exp);
    repeat (2) @(posedge clk);
    #1;
    total_checks++;
    if ({alert_n, ot_n, sd_n} !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t pins %b expected %b", $time, {alert_n, ot_n, sd_n}, exp);
    end
    // Realign so the caller's next drive lands on a rising edge
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    req <= 1'b1;
    req_addr <= a;
    exp_q.push_back(x);
    @(posedge clk);
    req <= 1'b0;
  endtask
  task automatic meas(input int c0, input int c1, input int c2, input int c3, input int c4);
    int v[5];
    v = '{c0, c1, c2, c3, c4};
    for (int i = 0; i < 5; i++) begin
      t_v[i] = {8'(v[i]), 3'b000};
    end
    t_v[2][2:0] = f;
    @(posedge clk);
    ch_temp <= t_v;
    meas_done <= 1'b1;
    @(posedge clk);
    meas_done <= 1'b0;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Read data is registered, so it is sampled at the falling edge one cycle after the request
  always @(posedge clk) begin
    stb_d <= rd_stb;
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  always @(negedge clk) begin
    if (stb_d === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("MISMATCH t=%0t unexpected read", $time);
      end else begin
        e = exp_q.pop_front();
        chk_byte(rd_data_r, e);
      end
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (8) lfsr = lfsr_next(lfsr);
    f = lfsr[2:0];
    for (int a = 8'h2A; a <= 8'h31; a++) begin
      rd(8'(a), 8'h00);
    end
    chk_pins(3'b111);
    meas(50, 50, 90, 50, 50);
    chk_pins(3'b011);
    rd(ADDR_SUMMARY, 8'h50);
    rd(ADDR_HOT_INT, 8'h5A);
    rd(ADDR_HOT_FRAC, {f, 5'b00000});
    rd(ADDR_UPPER, 8'h04);
    rd(ADDR_UPPER, 8'h00);
    rd(ADDR_SUMMARY, 8'h40);
    chk_pins(3'b111);
    conv_busy <= 1'b1;
    diode_fault <= 4'b0100;
    alert_mask <= 5'b00010;
    meas(50, 5, 70, 50, 50);
    chk_pins(3'b011);
    rd(ADDR_SUMMARY, 8'h24);
    rd(ADDR_LOWER, 8'h02);
    rd(ADDR_FAULT, 8'h08);
    rd(ADDR_SUMMARY, 8'h20);
    chk_pins(3'b111);
    diode_fault <= 4'b0000;
    alert_mask <= 5'b00000;
    meas(50, 5, 70, 50, 50);
    chk_pins(3'b011);
    rd(ADDR_SUMMARY, 8'h28);
    rd(ADDR_LOWER, 8'h02);
    rd(ADDR_SUMMARY, 8'h20);
    conv_busy <= 1'b0;
    meas(105, 50, 70, 50, 101);
    chk_pins(3'b001);
    rd(ADDR_SUMMARY, 8'h53);
    rd(ADDR_OVERTEMP, 8'h11);
    rd(ADDR_OVERTEMP, 8'h11);
    meas(90, 50, 70, 50, 97);
    rd(ADDR_OVERTEMP, 8'h10);
    rd(ADDR_SUMMARY, 8'h52);
    chk_pins(3'b001);
    meas(50, 50, 50, 50, 50);
    rd(ADDR_UPPER, 8'h11);
    rd(ADDR_OVERTEMP, 8'h00);
    rd(ADDR_SUMMARY, 8'h40);
    rd(8'h40, 8'h00);
    chk_pins(3'b111);
    meas(50, 125, 50, 50, 50);
    chk_pins(3'b000);
    rd(ADDR_OVERTEMP, 8'h82);
    rd(ADDR_SUMMARY, 8'h52);
    meas(50, 112, 50, 50, 50);
    rd(ADDR_OVERTEMP, 8'h82);
    rd(ADDR_SUMMARY, 8'h12);
    meas(50, 50, 50, 50, 50);
    rd(ADDR_UPPER, 8'h02);
    rd(ADDR_OVERTEMP, 8'h00);
    rd(ADDR_SUMMARY, 8'h40);
    chk_pins(3'b111);
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule
`default_nettype wire
